//--- tcp_pwm_core.sv
// Two-channel 8-bit PWM core with prescaler, scalers and Wishbone regs.
// Assumes a classic Wishbone master on clk_i and one pin per channel.
//
// Contract
// - Clocks A and B prescaled independently
// - Prescaler stops while both channels disabled
// - Scaled clock: reload down counter, halved
// - Scale zero means 256
// - Scale write reloads its down counter
// - Channel picks prescaled or scaled clock
// - Duty match toggles output flip-flop
// - Enable gated at selected clock edge
// - Polarity sets waveform start level
// - Enabled writes buffered until load point
// - Disabled writes update buffer and active
// - Counter read does not disturb channel
// - Counter write clears, loads, sets output
// - Disabled counter holds, resumes on enable
// - Disabled period zero clears on tick
// - Left aligned: count to period minus one
// - Center aligned: up, down, load at zero
// - Reset: disabled, stopped, counting up
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tcp_pwm_core
    import tcp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [5:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // PWM pins
    output logic      [1:0]  pwm_o
);
    // Duty offsets, local aliases of the packaged map
    localparam logic [5:0] OFS_DTY0 = TCP_OFS_DTY0;
    localparam logic [5:0] OFS_DTY1 = TCP_OFS_DTY1;

    // Software registers and channel state
    logic [7:0] channel_control_reg_r; // enables, select, polarity, align
    logic [7:0] prescale_select_reg_r; // clock A/B divide selects
    logic [7:0] scale_value_a_r;       // scaled clock A value
    logic [7:0] scale_value_b_r;       // scaled clock B value
    logic [7:0] per_buf_r [2];         // buffered period
    logic [7:0] dty_buf_r [2];         // buffered duty
    logic [7:0] per_act_r [2];         // active period
    logic [7:0] dty_act_r [2];         // active duty
    logic [7:0] chan_counter_r [2];    // channel counters
    logic [1:0] dir_down_r;            // count direction, 1 = down
    logic [1:0] ff_r;                  // output flip-flops
    logic [1:0] run_r;                 // enable synchronised to tick
    logic [1:0] per0_pend_r;           // period zero written while off

    // Field views
    logic [1:0] chan_enable;
    logic [1:0] chan_scaled_clk_sel;
    logic [1:0] chan_polarity;
    logic [1:0] center_align_sel;
    logic [2:0] clk_a_div_sel;
    logic [2:0] clk_b_div_sel;
    assign chan_enable         = channel_control_reg_r[TCP_CTL_EN +: 2];
    assign chan_scaled_clk_sel = channel_control_reg_r[TCP_CTL_SEL +: 2];
    assign chan_polarity       = channel_control_reg_r[TCP_CTL_POL +: 2];
    assign center_align_sel    = channel_control_reg_r[TCP_CTL_CAE +: 2];
    assign clk_a_div_sel       = prescale_select_reg_r[TCP_PRE_A +: 3];
    assign clk_b_div_sel       = prescale_select_reg_r[TCP_PRE_B +: 3];

    // Bus decode: single-cycle answer, ack dropped the cycle after
    logic       wr_stb;
    logic       rd_stb;
    logic [1:0] wr_cnt;
    logic [1:0] wr_per;
    logic [1:0] wr_dty;
    logic       wr_scla;
    logic       wr_sclb;
    assign wr_stb  = cyc_i && stb_i && !ack_o && we_i && sel_i[0];
    assign rd_stb  = cyc_i && stb_i && !ack_o && !we_i;
    assign wr_scla = wr_stb && (adr_i == TCP_OFS_SCLA);
    assign wr_sclb = wr_stb && (adr_i == TCP_OFS_SCLB);
    assign wr_cnt  = {wr_stb && (adr_i == TCP_OFS_CNT1),
                      wr_stb && (adr_i == TCP_OFS_CNT0)};
    assign wr_per  = {wr_stb && (adr_i == TCP_OFS_PER1),
                      wr_stb && (adr_i == TCP_OFS_PER0)};
    assign wr_dty  = {wr_stb && (adr_i == OFS_DTY1),
                      wr_stb && (adr_i == OFS_DTY0)};

    // Acknowledge every access, mapped or not
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= cyc_i && stb_i && !ack_o;
    end

    // Read mux; unmapped reads return zero, reads have no side effect
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= '0;
        else if (rd_stb)
        begin
            case (adr_i)
                TCP_OFS_CTRL:  dat_o <= {24'h0, channel_control_reg_r};
                TCP_OFS_PRESC: dat_o <= {24'h0, prescale_select_reg_r};
                TCP_OFS_SCLA:  dat_o <= {24'h0, scale_value_a_r};
                TCP_OFS_SCLB:  dat_o <= {24'h0, scale_value_b_r};
                TCP_OFS_CNT0:  dat_o <= {24'h0, chan_counter_r[0]};
                TCP_OFS_CNT1:  dat_o <= {24'h0, chan_counter_r[1]};
                TCP_OFS_PER0:  dat_o <= {24'h0, per_buf_r[0]};
                TCP_OFS_PER1:  dat_o <= {24'h0, per_buf_r[1]};
                OFS_DTY0:      dat_o <= {24'h0, dty_buf_r[0]};
                OFS_DTY1:      dat_o <= {24'h0, dty_buf_r[1]};
                default:       dat_o <= '0;
            endcase
        end
    end

    // Configuration registers, low byte lane only
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            channel_control_reg_r <= TCP_RST_BYTE;
            prescale_select_reg_r <= TCP_RST_BYTE;
            scale_value_a_r       <= TCP_RST_BYTE;
            scale_value_b_r       <= TCP_RST_BYTE;
        end
        else if (wr_stb)
        begin
            if (adr_i == TCP_OFS_CTRL)
                channel_control_reg_r <= dat_i[7:0];
            if (adr_i == TCP_OFS_PRESC)
                prescale_select_reg_r <= dat_i[7:0];
            if (wr_scla)
                scale_value_a_r <= dat_i[7:0];
            if (wr_sclb)
                scale_value_b_r <= dat_i[7:0];
        end
    end

    // Prescale counter; stopped when no channel is enabled to save power
    logic [6:0] pre_cnt_r;
    logic       pre_run;
    assign pre_run = |chan_enable;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pre_cnt_r <= 7'h00;
        else if (pre_run)
            pre_cnt_r <= pre_cnt_r + 7'h01;
    end

    // Tick when the low n bits are all ones: divide by 2^n
    logic [7:0] pre_mask_a;
    logic [7:0] pre_mask_b;
    logic       tick_a;
    logic       tick_b;
    assign pre_mask_a = (8'h01 << clk_a_div_sel) - 8'h01;
    assign pre_mask_b = (8'h01 << clk_b_div_sel) - 8'h01;
    assign tick_a = pre_run &&
        (({1'b0, pre_cnt_r} & pre_mask_a) == pre_mask_a);
    assign tick_b = pre_run &&
        (({1'b0, pre_cnt_r} & pre_mask_b) == pre_mask_b);

    // Scaled clocks: down counter reloads at one, output halved
    logic [7:0] sdn_r [2];
    logic [1:0] shalf_r;
    logic [1:0] stick;
    logic [1:0] ptick;
    logic [1:0] swr;
    logic [7:0] sval [2];
    assign ptick   = {tick_b, tick_a};
    assign swr     = {wr_sclb, wr_scla};
    assign sval[0] = dat_i[7:0];
    assign sval[1] = dat_i[7:0];
    // Zero wraps to 255 on decrement, so it counts 256 ticks
    always_ff @(posedge clk_i)
    begin
        for (int k = 0; k < 2; k++)
        begin
            if (rst_i)
            begin
                sdn_r[k]   <= TCP_RST_BYTE;
                shalf_r[k] <= 1'b0;
            end
            else if (swr[k])
                sdn_r[k] <= sval[k];
            else if (ptick[k])
            begin
                if (sdn_r[k] == TCP_CNT_ONE)
                begin
                    sdn_r[k]   <= (k == 0) ? scale_value_a_r
                                           : scale_value_b_r;
                    shalf_r[k] <= ~shalf_r[k];
                end
                else
                    sdn_r[k] <= sdn_r[k] - 8'h01;
            end
        end
    end
    // Scaled tick on every second reload pulse
    assign stick[0] = ptick[0] && (sdn_r[0] == TCP_CNT_ONE) && shalf_r[0];
    assign stick[1] = ptick[1] && (sdn_r[1] == TCP_CNT_ONE) && shalf_r[1];

    // Channel clock select
    logic [1:0] ctick;
    assign ctick[0] = chan_scaled_clk_sel[0] ? stick[0] : ptick[0];
    assign ctick[1] = chan_scaled_clk_sel[1] ? stick[1] : ptick[1];

    // Channel timers
    always_ff @(posedge clk_i)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (rst_i)
            begin
                chan_counter_r[c] <= TCP_RST_BYTE;
                dir_down_r[c]     <= 1'b0;
                ff_r[c]           <= 1'b0;
                run_r[c]          <= 1'b0;
                per_buf_r[c]      <= TCP_RST_BYTE;
                dty_buf_r[c]      <= TCP_RST_BYTE;
                per_act_r[c]      <= TCP_RST_BYTE;
                dty_act_r[c]      <= TCP_RST_BYTE;
                per0_pend_r[c]    <= 1'b0;
            end
            else
            begin
                // Enable and clock only meet at a tick edge
                if (!chan_enable[c])
                    run_r[c] <= 1'b0;
                else if (ctick[c])
                    run_r[c] <= 1'b1;
                // Buffer writes; straight through while disabled
                if (wr_per[c])
                begin
                    per_buf_r[c] <= dat_i[7:0];
                    if (!chan_enable[c])
                        per_act_r[c] <= dat_i[7:0];
                end
                if (wr_dty[c])
                begin
                    dty_buf_r[c] <= dat_i[7:0];
                    if (!chan_enable[c])
                        dty_act_r[c] <= dat_i[7:0];
                end
                // Armed by a zero period, disarmed by any other value
                if (wr_per[c] && !chan_enable[c])
                    per0_pend_r[c] <= (dat_i[7:0] == 8'h00);
                if (chan_enable[c] == 1'b0 && run_r[c])
                begin
                    per_act_r[c] <= per_buf_r[c];
                    dty_act_r[c] <= dty_buf_r[c];
                end
                if (wr_cnt[c])
                begin
                    chan_counter_r[c] <= 8'h00;
                    dir_down_r[c]     <= 1'b0;
                    per_act_r[c]      <= per_buf_r[c];
                    dty_act_r[c]      <= dty_buf_r[c];
                    ff_r[c]           <= 1'b0;
                end
                // Count stops the very cycle the enable drops
                else if (!run_r[c] || !chan_enable[c])
                begin
                    // Held count; period zero clears on next tick
                    if (ctick[c] && per0_pend_r[c])
                    begin
                        chan_counter_r[c] <= 8'h00;
                        // A zero write in this same cycle re-arms it
                        per0_pend_r[c]    <= wr_per[c] && !chan_enable[c]
                                             && dat_i[7:0] == 8'h00;
                    end
                end
                else if (ctick[c])
                begin
                    if (!center_align_sel[c])
                    begin
                        if (chan_counter_r[c] + 8'h01 >= per_act_r[c])
                        begin
                            chan_counter_r[c] <= 8'h00;
                            ff_r[c]           <= 1'b0;
                            per_act_r[c]      <= per_buf_r[c];
                            dty_act_r[c]      <= dty_buf_r[c];
                        end
                        else
                        begin
                            chan_counter_r[c] <= chan_counter_r[c] + 8'h01;
                            if (chan_counter_r[c] + 8'h01 == dty_act_r[c])
                                ff_r[c] <= ~ff_r[c];
                        end
                    end
                    else
                    begin
                        // Center aligned: turn at period, load at zero
                        if (!dir_down_r[c] &&
                            chan_counter_r[c] + 8'h01 >= per_act_r[c])
                        begin
                            dir_down_r[c]     <= 1'b1;
                            chan_counter_r[c] <= per_act_r[c];
                            if (per_act_r[c] == dty_act_r[c])
                                ff_r[c] <= ~ff_r[c];
                        end
                        else if (dir_down_r[c] &&
                                 chan_counter_r[c] <= 8'h01)
                        begin
                            dir_down_r[c]     <= 1'b0;
                            chan_counter_r[c] <= 8'h00;
                            ff_r[c]           <= 1'b0;
                            per_act_r[c]      <= per_buf_r[c];
                            dty_act_r[c]      <= dty_buf_r[c];
                        end
                        else if (dir_down_r[c])
                        begin
                            chan_counter_r[c] <= chan_counter_r[c] - 8'h01;
                            if (chan_counter_r[c] - 8'h01 == dty_act_r[c])
                                ff_r[c] <= ~ff_r[c];
                        end
                        else
                        begin
                            chan_counter_r[c] <= chan_counter_r[c] + 8'h01;
                            if (chan_counter_r[c] + 8'h01 == dty_act_r[c])
                                ff_r[c] <= ~ff_r[c];
                        end
                    end
                end
            end
        end
    end

    // Output pins: polarity selects Q or inverted Q, enabled at once
    always_ff @(posedge clk_i)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (rst_i)
                pwm_o[c] <= 1'b0;
            else if (chan_enable[c])
                pwm_o[c] <= ff_r[c] ^ chan_polarity[c];
            else
                pwm_o[c] <= 1'b0;
        end
    end

    // Assertions
    a_ack_one_cycle:
    assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_cnt_write_clears:
    assert property (@(posedge clk_i) disable iff (rst_i)
        wr_cnt[0] |=> chan_counter_r[0] == 8'h00 && !dir_down_r[0])
        else $error("counter write did not clear");
    a_hold_disabled:
    assert property (@(posedge clk_i) disable iff (rst_i)
        !run_r[0] && !wr_cnt[0] && !per0_pend_r[0]
        |=> $stable(chan_counter_r[0]))
        else $error("disabled counter moved");
    a_prescale_stop:
    assert property (@(posedge clk_i) disable iff (rst_i)
        chan_enable == 2'b00 |=> $stable(pre_cnt_r))
        else $error("prescaler ran while idle");
    a_scale_reload:
    assert property (@(posedge clk_i) disable iff (rst_i)
        wr_scla |=> sdn_r[0] == $past(dat_i[7:0]))
        else $error("scale write did not reload");
    a_disabled_write:
    assert property (@(posedge clk_i) disable iff (rst_i)
        wr_per[0] && !chan_enable[0] |=> per_act_r[0] == per_buf_r[0])
        else $error("disabled period write not active");
    a_left_range:
    assert property (@(posedge clk_i) disable iff (rst_i)
        run_r[0] && !center_align_sel[0] && per_act_r[0] != 8'h00
        && chan_counter_r[0] < per_act_r[0] && !wr_cnt[0]
        |=> chan_counter_r[0] < $past(per_act_r[0]))
        else $error("left aligned count overran period");
    a_pin_polarity:
    assert property (@(posedge clk_i) disable iff (rst_i)
        wr_cnt[0] && chan_enable[0] && $stable(chan_polarity[0])
        ##1 chan_enable[0] |=> pwm_o[0] == chan_polarity[0])
        else $error("output not at polarity after counter write");
    a_enable_edge:
    assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(run_r[0]) |-> $past(ctick[0]))
        else $error("channel started off a tick edge");
endmodule // tcp_pwm_core
`default_nettype wire

//--- tcp_pkg.sv
// Package for the two-channel PWM core: register map, resets, encodings.
// Assumes a classic Wishbone slave with 32-bit data, byte offsets below.
package tcp_pkg;
    // Register byte offsets (word aligned); ten words need six bits
    localparam logic [5:0] TCP_OFS_CTRL   = 6'h00; // enables, select, align
    localparam logic [5:0] TCP_OFS_PRESC  = 6'h04; // prescale selects
    localparam logic [5:0] TCP_OFS_SCLA   = 6'h08; // scale value A
    localparam logic [5:0] TCP_OFS_SCLB   = 6'h0C; // scale value B
    localparam logic [5:0] TCP_OFS_CNT0   = 6'h10; // channel 0 counter
    localparam logic [5:0] TCP_OFS_CNT1   = 6'h14; // channel 1 counter
    localparam logic [5:0] TCP_OFS_PER0   = 6'h18; // channel 0 period
    localparam logic [5:0] TCP_OFS_PER1   = 6'h1C; // channel 1 period
    localparam logic [5:0] TCP_OFS_DTY0   = 6'h20; // channel 0 duty
    localparam logic [5:0] TCP_OFS_DTY1   = 6'h24; // channel 1 duty
    // Control field positions
    localparam int TCP_CTL_EN   = 0; // bits 1:0 channel enables
    localparam int TCP_CTL_SEL  = 2; // bits 3:2 scaled clock select
    localparam int TCP_CTL_POL  = 4; // bits 5:4 polarity
    localparam int TCP_CTL_CAE  = 6; // bits 7:6 center align
    localparam int TCP_PRE_A    = 0; // bits 2:0 clock A divide select
    localparam int TCP_PRE_B    = 4; // bits 6:4 clock B divide select
    // Reset value and scaled counter reload point
    localparam logic [7:0] TCP_RST_BYTE = 8'h00;
    localparam logic [7:0] TCP_CNT_ONE  = 8'h01;
endpackage : tcp_pkg

//--- tb.sv
// Self-checking bench for the two-channel PWM core: registers and waveforms.
// Assumes tcp_pkg and tcp_pwm_core are compiled first; needs nothing else.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tcp_pkg::*;
    localparam int         CYC_LIMIT = 60000;        // Whole run fits well
    localparam logic [5:0] OFS_DUTY0 = TCP_OFS_DTY0; // Duty 0 as packaged
    // Design ports
    logic        clk_i;
    logic        rst_i;
    logic        cyc_i;
    logic        stb_i;
    logic        we_i;
    logic [5:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [1:0]  pwm_o;
    // Bench state
    int          fail_count;
    int          num_checks;
    int          seed;
    int          cycles;      // Free-running cycle count
    int          shadow [10]; // Model of the register file
    logic [31:0] rd;          // Last read data
    logic [31:0] rnd;
    int          t0;
    int          t1;
    int          t2;
    int          n;

    tcp_pwm_core uut (
        .clk_i (clk_i), .rst_i (rst_i), .cyc_i (cyc_i), .stb_i (stb_i),
        .we_i  (we_i),  .adr_i (adr_i), .sel_i (sel_i), .dat_i (dat_i),
        .dat_o (dat_o), .ack_o (ack_o), .pwm_o (pwm_o)
    );

    // Clock at 40 MHz
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Cycle counter and hang guard
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == CYC_LIMIT)
        begin
            fail_count++;
            close_out();
        end
    end

    // Verdict and end of run
    task close_out();
        if (fail_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Compare tasks, one per kind of result
    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_time(input int got, input int exp);
        num_checks++;
        if (got != exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_pin(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic Wishbone cycle; holds everything until ack is sampled
    task wb(input logic w, input logic [5:0] a, input logic [7:0] d);
        logic [31:0] r;
        r = $random(seed);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= {r[31:8], d};  // Upper bytes random, must be ignored
        do
            @(posedge clk_i);
        while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask
    // Write that the model remembers, and a read checked against it
    task wr(input logic [5:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
        shadow[a[5:2]] = d;
    endtask
    task rdchk(input logic [5:0] a);
        wb(1'b0, a, 8'h00);
        chk_reg(rd, 32'(shadow[a[5:2]]));
    endtask

    // Wait until a pin is first seen at a level after being away from it
    task wait_edge(input int ch, input logic lvl);
        logic p;
        p = pwm_o[ch];
        forever
        begin
            @(posedge clk_i);
            if (pwm_o[ch] === lvl && p !== lvl)
                break;
            p = pwm_o[ch];
        end
    endtask

    // Rise-to-rise period and rise-to-fall high time, in clock cycles
    task measure(output int pr, output int hi);
        int s;
        wait_edge(0, 1'b1);
        s = cycles;
        wait_edge(0, 1'b0);
        hi = cycles - s;
        wait_edge(0, 1'b1);
        pr = cycles - s;
    endtask

    // Set up channel 0 from a clean start and compare with the model
    task wave(input logic [7:0] pre, input logic [7:0] scl,
              input logic [7:0] ctl, input int per, input int dty);
        int div;
        int pr;
        int hi;
        div = 1 << pre[2:0];
        if (ctl[2])
            div = div * 2 * ((scl == 8'h00) ? 256 : int'(scl));
        wr(TCP_OFS_CTRL, 8'h00);  // Stop before clock changes
        wr(TCP_OFS_PRESC, pre);
        wr(TCP_OFS_SCLA, scl);
        wr(TCP_OFS_PER0, per[7:0]);
        wr(OFS_DUTY0, dty[7:0]);
        wb(1'b1, TCP_OFS_CNT0, 8'h00);     // Known start
        wr(TCP_OFS_CTRL, ctl);
        measure(pr, hi);                   // First cycle may be irregular
        measure(pr, hi);
        if (ctl[6])
        begin
            chk_time(pr, 2 * per * div);
            chk_time(hi, 2 * dty * div);
        end
        else
        begin
            chk_time(pr, per * div);
            chk_time(hi, (ctl[4] ? dty : per - dty) * div);
        end
    endtask

    // Main sequence
    initial
    begin
        seed = 74404;
        fail_count = 0;
        num_checks = 0;
        cycles = 0;
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i  = 1'b0;
        adr_i = 6'h00;
        sel_i = 4'h0;
        dat_i = 32'h0;
        for (n = 0; n < 10; n++)
            shadow[n] = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        // Out of reset everything reads zero and pins are low
        chk_reg({30'h0, pwm_o}, 32'h0);
        for (n = 0; n < 10; n++)
            rdchk(6'(n * 4));
        // Random register traffic, channels kept off
        for (n = 0; n < 4; n++)
        begin
            rnd = $random(seed);
            wr(TCP_OFS_PRESC, rnd[7:0] & 8'h77);
            rdchk(TCP_OFS_PRESC);
            wr(TCP_OFS_SCLA, rnd[15:8]);
            rdchk(TCP_OFS_SCLA);
            wr(TCP_OFS_SCLB, rnd[23:16]);
            rdchk(TCP_OFS_SCLB);
            wr(TCP_OFS_PER1, rnd[31:24]);
            rdchk(TCP_OFS_PER1);
            wr(TCP_OFS_CTRL, rnd[7:0] & 8'hFC);
            rdchk(TCP_OFS_CTRL);
        end
        // Every prescale setting, both polarities, B set differently
        for (n = 0; n < 8; n++)
            wave(8'(n) | 8'((7 - n) << 4), 8'h00,
                 8'h01 | (n[0] ? 8'h10 : 8'h00), 4, 1);
        // Scaled clock A, including the full-scale zero value
        wave(8'h01, 8'h01, 8'h15, 4, 1);
        wave(8'h01, 8'h03, 8'h15, 4, 1);
        wave(8'h01, 8'h00, 8'h15, 4, 1);
        // Center aligned
        wave(8'h00, 8'h00, 8'h51, 4, 1);
        // Period write while running waits for the period end
        wave(8'h03, 8'h00, 8'h11, 4, 2);
        wait_edge(0, 1'b1);
        t0 = cycles;
        wr(TCP_OFS_PER0, 8'h06);
        rdchk(TCP_OFS_PER0);
        wb(1'b0, TCP_OFS_CNT0, 8'h00);                       // Read mid-run
        wait_edge(0, 1'b1);
        t1 = cycles;
        wait_edge(0, 1'b1);
        t2 = cycles;
        chk_time(t1 - t0, 32);
        chk_time(t2 - t1, 48);
        // Counter write while running restarts from zero at polarity level
        wb(1'b1, TCP_OFS_CNT0, 8'h5A);
        wb(1'b0, TCP_OFS_CNT0, 8'h00);
        chk_reg({31'h0, rd < 32'h2}, 32'h1);
        chk_pin(pwm_o[0], 1'b1);
        // Channel 0 off, channel 1 keeps the prescaler running
        wr(TCP_OFS_CTRL, 8'h12);
        wb(1'b0, TCP_OFS_CNT0, 8'h00);
        rnd = rd;
        repeat (40) @(posedge clk_i);
        wb(1'b0, TCP_OFS_CNT0, 8'h00);
        chk_reg(rd, rnd);
        chk_pin(pwm_o[0], 1'b0);
        wr(TCP_OFS_PER0, 8'h00);
        repeat (20) @(posedge clk_i);
        wb(1'b0, TCP_OFS_CNT0, 8'h00);
        chk_reg(rd, 32'h0);
        // Disabled writes take effect without a counter write
        wr(TCP_OFS_PER0, 8'h03);
        wr(OFS_DUTY0, 8'h01);
        rdchk(OFS_DUTY0);
        wr(TCP_OFS_CTRL, 8'h13);
        measure(t1, t2);
        measure(t1, t2);
        chk_time(t1, 24);
        close_out();
    end
endmodule // tb
`default_nettype wire
